/* File: serial_frame_check_defs.vh */
// Purpose: Shared constants of the frame check block.
// Assumes: 200 MHz aclk, AXI4-Lite register access with 32-bit data.
// Notes: Definitions only; included by bare name.
// How it works
// (RULE_01) ASCII check byte: negated byte sum modulo 256
// (RULE_02) ASCII check sent as two hex characters
// (RULE_03) RTU checksum register starts at all ones
// (RULE_04) Each byte XORed into checksum low byte
// (RULE_05) Shift right; XOR A001 if bit out set
// (RULE_06) Exactly eight shift steps per byte
// (RULE_07) Checksum covers address through last data byte
// (RULE_08) RTU checksum sent low byte first
// (RULE_09) ASCII frame ends with CR then LF
// (RULE_10) RTU frame ends after idle over 10 ms
// (RULE_11) Basic, extension, communication groups writable in range
// (RULE_12) Monitor and diagnosis writable except listed numbers
// (RULE_13) Reads allowed only within each group's range
// (RULE_14) New baud rate applies from next exchange
// (RULE_15) New protocol format applies from next exchange
// (RULE_16) Forced output values one-hot drive outputs one-six
// (RULE_17) Adjust select writable after 14H and restart
// (RULE_18) Offset adjust writable after 16H and restart
// (RULE_19) Fault code and history readable as parameters
// (RULE_20) Station address valid only from 1 to 254
// (RULE_21) Read command 03H, at most ten words
// (RULE_22) Write command 06H writes one word, echoed
// (RULE_23) Frames failing check are discarded unacted
// (RULE_24) Out-of-set reads and writes rejected, values kept
`ifndef SERIAL_FRAME_CHECK_DEFS_VH
`define SERIAL_FRAME_CHECK_DEFS_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_FRAME 8'h08
`define REG_PSEL 8'h0c
`define REG_PDATA 8'h10
`define REG_LINK 8'h14

// Field positions, reset values and the lowest RTU protocol value
`define CTRL_RESTART_BIT 8
`define STATION_RESET 8'h01
`define BAUD_RESET 16'h0000
`define PROTO_RESET 16'h0000
`define PROTO_RTU_MIN 16'h0006

// Checks and framing characters
`define CRC_PRESET 16'hffff
`define CRC_POLY 16'ha001
`define CHR_START 8'h3a
`define CHR_CR 8'h0d
`define CHR_LF 8'h0a
`define CMD_READ 8'h03
`define CMD_WRITE 8'h06
`define READ_MAX 16'h000a
`define ADDR_MIN 8'h01
`define ADDR_MAX 8'hfe
`define LEN_ASCII 4'h7
`define LEN_RTU 4'h8

// Special parameter addresses, group in high byte, then the two unlock values
`define PAR_FAULT_CODE 16'h0001
`define PAR_SPECIAL_FN 16'h0208
`define PAR_BAUD 16'h0301
`define PAR_PROTO 16'h0302
`define PAR_FORCED_OUT 16'h0406
`define PAR_ADJ_SELECT 16'h040a
`define UNLOCK_ADJ 16'h0014
`define UNLOCK_OFFSET 16'h0016

// Frame verdict codes
`define VERD_NONE 3'h0
`define VERD_OK 3'h1
`define VERD_BAD_CHECK 3'h2
`define VERD_OTHER_STN 3'h3
`define VERD_BAD_CMD 3'h4
`define VERD_DENIED 3'h5

// Silent cycles of 10 ms at 200 MHz
`define IDLE_CYCLES 24'd2000000

`endif

/* File: param_store.v */
// Purpose: Parameter word memory with a registered read port.
// Assumes: Index is {group[2:0], number[6:0]}.
// Notes: Contents are not reset; read data lag the address by one clock.
`timescale 1ns/100ps
module param_store (
  input wire aclk,
  input wire we,
  input wire [9:0] waddr,
  input wire [15:0] wdata,
  input wire [9:0] raddr,
  output reg [15:0] rdata
);
  // Parameter words
  reg [15:0] mem [0:1023];

  // Write and registered read
  always @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* File: serial_frame_check_access.v */
// Purpose: Frame checks, frame end and parameter access for the link.
// Assumes: Bytes arrive from a UART engine one per rx_valid pulse; one clock domain.
// Notes: Software reaches control, status and the parameter store over AXI4-Lite.
`timescale 1ns/100ps
`include "serial_frame_check_defs.vh"
module serial_frame_check_access #(
  parameter [23:0] IDLE_CYCLES = `IDLE_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire tx_in_valid,
  output wire tx_in_ready,
  input wire [7:0] tx_in_data,
  input wire tx_in_last,
  output reg tx_out_valid,
  input wire tx_out_ready,
  output reg [7:0] tx_out_data,
  output reg tx_out_last,
  input wire [15:0] fault_code,
  input wire [79:0] fault_history,
  output wire rtu_mode,
  output reg [15:0] baud_sel,
  output reg [5:0] digital_out,
  output reg frame_done,
  output reg [2:0] frame_verdict,
  output reg read_req,
  output reg [15:0] read_start,
  output reg [3:0] read_count
);
  // Receive and transmit states
  localparam [1:0] R_HUNT = 2'd0;
  localparam [1:0] R_BODY = 2'd1;
  localparam [1:0] R_CR = 2'd2;
  localparam [2:0] T_PAY = 3'd0;
  localparam [2:0] T_CK1 = 3'd1;
  localparam [2:0] T_CK2 = 3'd2;
  localparam [2:0] T_CR = 3'd3;
  localparam [2:0] T_LF = 3'd4;

  // One byte through the checksum
  function [15:0] crc_byte;
    input [15:0] crc;
    input [7:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc ^ {8'h00, data}; // RULE_04
      for (i = 0; i < 8; i = i + 1) begin // RULE_06
        c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1); // RULE_05
      end
      crc_byte = c;
    end
  endfunction

  // Hex character to {valid, nibble}
  function [4:0] hex_val;
    input [7:0] ch;
    begin
      hex_val = (ch >= 8'h30 && ch <= 8'h39) ? {1'b1, ch[3:0]} :
                (ch >= 8'h41 && ch <= 8'h46) ? {1'b1, ch[3:0] + 4'h9} : 5'h00;
    end
  endfunction

  // Nibble to upper-case hex character
  function [7:0] hex_chr;
    input [3:0] n;
    begin
      hex_chr = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    end
  endfunction

  // Parameter numbers that the link may read
  function readable;
    input [7:0] grp;
    input [7:0] num;
    begin
      case (grp) // RULE_13
        8'h00: readable = (num <= 8'd46);
        8'h01: readable = (num <= 8'd76);
        8'h02: readable = (num <= 8'd67);
        8'h03: readable = (num <= 8'd11);
        8'h04: readable = (num <= 8'd24);
        default: readable = 1'b0;
      endcase
    end
  endfunction

  // Link-writable numbers under the unlock value
  function writable;
    input [7:0] grp;
    input [7:0] num;
    input [15:0] unlock;
    begin
      case (grp)
        8'h00: writable = (num <= 8'd46) && (num > 8'd1) && (num != 8'd46) &&
                          !(num >= 8'd8 && num <= 8'd13); // RULE_12
        8'h01: writable = (num <= 8'd76); // RULE_11
        8'h02: writable = (num <= 8'd67); // RULE_11
        8'h03: writable = (num <= 8'd11); // RULE_11
        8'h04: begin
          if (num <= 8'd4 || num == 8'd8 || num == 8'd9 || num > 8'd24) begin
            writable = 1'b0; // RULE_12
          end else if ({8'h00, num} == (`PAR_ADJ_SELECT & 16'h00ff)) begin
            writable = (unlock == `UNLOCK_ADJ); // RULE_17
          end else if (num >= 8'd11 && num <= 8'd21) begin
            writable = (unlock == `UNLOCK_OFFSET); // RULE_18
          end else begin
            writable = 1'b1;
          end
        end
        default: writable = 1'b0;
      endcase
    end
  endfunction

  // Control state
  reg [7:0] station_q; // Own station address
  reg [15:0] special_q; // Last special-function value written
  reg [15:0] unlock_q; // Special-function value taken at restart
  reg [15:0] baud_pend_q; // Written baud value waiting for exchange end
  reg [15:0] proto_pend_q; // Written protocol value waiting for exchange end
  reg [15:0] proto_q; // Active protocol value
  reg pend_q; // A baud or protocol change is waiting
  reg [9:0] psel_q; // Parameter index for software access
  // AXI holding registers
  reg aw_q;
  reg [7:0] awaddr_q;
  reg w_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg ar_q;
  reg [7:0] araddr_q;
  // Receive state
  reg [1:0] rst_q;
  reg half_q; // High nibble held
  reg [3:0] hi_q;
  reg bad_q; // Non-hex character seen in frame
  reg [7:0] sum_q;
  reg [15:0] crc_q;
  reg [3:0] cnt_q; // Bytes in frame, saturating
  reg [23:0] idle_q; // Silent cycles since last byte
  reg [7:0] cap_q [0:5]; // Address, command, start and data bytes
  // Transmit state
  reg [2:0] tst_q;
  reg thalf_q;
  reg [3:0] thi_q;
  reg [7:0] tsum_q;
  reg [15:0] tcrc_q;
  wire [15:0] mem_rdata;

  assign rtu_mode = (proto_q >= `PROTO_RTU_MIN); // RULE_15

  // Incoming byte event, both modes
  wire [4:0] rx_hex = hex_val(rx_data);
  reg byte_ev;
  reg [7:0] byte_v;
  always @* begin
    if (rtu_mode) begin
      byte_ev = rx_valid && (rst_q != R_CR);
      byte_v = rx_data;
    end else begin
      byte_ev = rx_valid && (rst_q == R_BODY) && rx_hex[4] && half_q;
      byte_v = {hi_q, rx_hex[3:0]};
    end
  end

  // Frame end: CR LF in ASCII, long silence in RTU
  wire end_ev = rtu_mode ? ((rst_q == R_BODY) && !rx_valid && (idle_q >= IDLE_CYCLES)) : // RULE_10
                           ((rst_q == R_CR) && rx_valid && (rx_data == `CHR_LF)); // RULE_09

  // Frame evaluation
  wire [15:0] f_start = {cap_q[2], cap_q[3]};
  wire [15:0] f_word = {cap_q[4], cap_q[5]};
  wire [7:0] f_last = cap_q[3] + cap_q[5] - 8'h01;
  wire chk_ok = !bad_q && (rtu_mode ? (crc_q == 16'h0000) : (sum_q == 8'h00)); // RULE_23
  wire len_ok = (cnt_q == (rtu_mode ? `LEN_RTU : `LEN_ASCII));
  wire stn_ok = (cap_q[0] >= `ADDR_MIN) && (cap_q[0] <= `ADDR_MAX) &&
                (cap_q[0] == station_q); // RULE_20
  wire is_rd = len_ok && (cap_q[1] == `CMD_READ);
  wire is_wr = len_ok && (cap_q[1] == `CMD_WRITE);
  wire rd_ok = (f_word != 16'h0000) && (f_word <= `READ_MAX) && // RULE_21
               readable(cap_q[2], cap_q[3]) && readable(cap_q[2], f_last); // RULE_24
  wire wr_ok = writable(cap_q[2], cap_q[3], unlock_q); // RULE_24
  reg [2:0] verdict;
  always @* begin
    if (!chk_ok) begin
      verdict = `VERD_BAD_CHECK; // RULE_23
    end else if (!stn_ok) begin
      verdict = `VERD_OTHER_STN;
    end else if (!is_rd && !is_wr) begin
      verdict = `VERD_BAD_CMD;
    end else if ((is_rd && rd_ok) || (is_wr && wr_ok)) begin
      verdict = `VERD_OK;
    end else begin
      verdict = `VERD_DENIED; // RULE_24
    end
  end
  wire link_we = end_ev && is_wr && (verdict == `VERD_OK); // RULE_22

  // Receive framing and check accumulation
  always @(posedge aclk) begin
    if (!aresetn) begin
      rst_q <= R_HUNT;
      half_q <= 1'b0;
      hi_q <= 4'h0;
      bad_q <= 1'b0;
      sum_q <= 8'h00;
      crc_q <= `CRC_PRESET;
      cnt_q <= 4'h0;
      idle_q <= 24'h000000;
    end else begin
      // Silence counter restarts on every byte
      idle_q <= rx_valid ? 24'h000000 : ((idle_q == 24'hffffff) ? idle_q : idle_q + 24'h000001);
      if (rst_q == R_HUNT && !byte_ev) begin
        sum_q <= 8'h00;
        crc_q <= `CRC_PRESET; // RULE_03
        cnt_q <= 4'h0;
        half_q <= 1'b0;
        bad_q <= 1'b0;
      end
      if (byte_ev) begin
        sum_q <= sum_q + byte_v; // RULE_01
        crc_q <= crc_byte(crc_q, byte_v); // RULE_07
        cnt_q <= (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
      end
      case (rst_q)
        R_HUNT: begin
          if (rx_valid && (rtu_mode || rx_data == `CHR_START)) begin
            rst_q <= R_BODY;
          end
        end
        R_BODY: begin
          if (end_ev) begin
            rst_q <= R_HUNT;
          end else if (!rtu_mode && rx_valid) begin
            if (rx_data == `CHR_CR) begin
              rst_q <= R_CR;
            end else if (rx_hex[4]) begin
              half_q <= !half_q;
              hi_q <= rx_hex[3:0];
            end else begin
              bad_q <= 1'b1;
            end
          end
        end
        R_CR: begin
          // Anything but LF after CR drops the frame
          rst_q <= (rx_valid || rtu_mode) ? R_HUNT : R_CR;
        end
        default: rst_q <= R_HUNT;
      endcase
    end
  end

  // Leading frame bytes, one register each
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : cap
      always @(posedge aclk) begin
        if (!aresetn) begin
          cap_q[gi] <= 8'h00;
        end else if (byte_ev && cnt_q == gi) begin
          cap_q[gi] <= byte_v;
        end
      end
    end
  endgenerate

  // Frame result outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      frame_done <= 1'b0;
      frame_verdict <= `VERD_NONE;
      read_req <= 1'b0;
      read_start <= 16'h0000;
      read_count <= 4'h0;
    end else begin
      frame_done <= end_ev;
      read_req <= end_ev && is_rd && (verdict == `VERD_OK);
      if (end_ev) begin
        frame_verdict <= verdict;
        read_start <= f_start;
        read_count <= f_word[3:0];
      end
    end
  end

  // Transmit trailer generation
  wire tx_slot = !tx_out_valid || tx_out_ready;
  assign tx_in_ready = (tst_q == T_PAY) && tx_slot;
  wire tx_push = tx_in_valid && tx_in_ready;
  wire [4:0] tx_hex = hex_val(tx_in_data);
  wire [7:0] tx_lrc = 8'h00 - tsum_q; // RULE_01
  wire tx_end = tx_out_valid && tx_out_ready && tx_out_last;
  always @(posedge aclk) begin
    if (!aresetn) begin
      tst_q <= T_PAY;
      thalf_q <= 1'b0;
      thi_q <= 4'h0;
      tsum_q <= 8'h00;
      tcrc_q <= `CRC_PRESET;
      tx_out_valid <= 1'b0;
      tx_out_data <= 8'h00;
      tx_out_last <= 1'b0;
    end else begin
      if (tx_slot) begin
        tx_out_valid <= 1'b0;
      end
      case (tst_q)
        T_PAY: begin
          if (tx_push) begin
            tx_out_valid <= 1'b1;
            tx_out_data <= tx_in_data;
            tx_out_last <= 1'b0;
            tcrc_q <= crc_byte(tcrc_q, tx_in_data); // RULE_07
            if (tx_hex[4]) begin
              thalf_q <= !thalf_q;
              thi_q <= tx_hex[3:0];
              if (thalf_q) begin
                tsum_q <= tsum_q + {thi_q, tx_hex[3:0]};
              end
            end
            if (tx_in_last) begin
              tst_q <= T_CK1;
            end
          end
        end
        T_CK1: begin
          if (tx_slot) begin
            tx_out_valid <= 1'b1;
            tx_out_data <= rtu_mode ? tcrc_q[7:0] : hex_chr(tx_lrc[7:4]); // RULE_08 RULE_02
            tst_q <= T_CK2;
          end
        end
        T_CK2: begin
          if (tx_slot) begin
            tx_out_valid <= 1'b1;
            tx_out_data <= rtu_mode ? tcrc_q[15:8] : hex_chr(tx_lrc[3:0]); // RULE_08 RULE_02
            tx_out_last <= rtu_mode;
            tst_q <= rtu_mode ? T_PAY : T_CR;
          end
        end
        T_CR: begin
          if (tx_slot) begin
            tx_out_valid <= 1'b1;
            tx_out_data <= `CHR_CR; // RULE_09
            tst_q <= T_LF;
          end
        end
        T_LF: begin
          if (tx_slot) begin
            tx_out_valid <= 1'b1;
            tx_out_data <= `CHR_LF; // RULE_09
            tx_out_last <= 1'b1;
            tst_q <= T_PAY;
          end
        end
        default: tst_q <= T_PAY;
      endcase
      // Trailer done: accumulators back to their start values
      if (tx_slot && ((tst_q == T_CK2 && rtu_mode) || tst_q == T_LF)) begin
        tsum_q <= 8'h00;
        tcrc_q <= `CRC_PRESET; // RULE_03
        thalf_q <= 1'b0;
      end
    end
  end

  // AXI write: address and data in either order
  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  wire wr_go = aw_q && w_q && !s_axi_bvalid && !link_we;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire wr_map = (awaddr_q <= `REG_LINK) && (awaddr_q[1:0] == 2'b00); // Six word offsets
  wire sw_we = wr_go && (awaddr_q == `REG_PDATA);
  wire [15:0] sw_wdata = (mem_rdata & ~wmask[15:0]) | (wdata_q[15:0] & wmask[15:0]);
  wire [15:0] lw_val = f_word;

  // Control registers and AXI write handling
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      awaddr_q <= 8'h00;
      w_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      station_q <= `STATION_RESET;
      special_q <= 16'h0000;
      unlock_q <= 16'h0000;
      baud_pend_q <= `BAUD_RESET;
      proto_pend_q <= `PROTO_RESET;
      baud_sel <= `BAUD_RESET;
      proto_q <= `PROTO_RESET;
      pend_q <= 1'b0;
      psel_q <= 10'h000;
      digital_out <= 6'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? 2'b00 : 2'b10;
        if (awaddr_q == `REG_CTRL) begin
          station_q <= (station_q & ~wmask[7:0]) | (wdata_q[7:0] & wmask[7:0]);
          if (wstrb_q[1] && wdata_q[`CTRL_RESTART_BIT]) begin
            unlock_q <= special_q; // RULE_17 RULE_18
          end
        end
        if (awaddr_q == `REG_PSEL) begin
          psel_q <= (psel_q & ~wmask[9:0]) | (wdata_q[9:0] & wmask[9:0]);
        end
      end
      // Accepted link write side effects
      if (link_we) begin
        if (f_start == `PAR_SPECIAL_FN) begin
          special_q <= lw_val;
        end
        if (f_start == `PAR_BAUD) begin
          baud_pend_q <= lw_val;
          pend_q <= 1'b1;
        end
        if (f_start == `PAR_PROTO) begin
          proto_pend_q <= lw_val;
          pend_q <= 1'b1;
        end
        if (f_start == `PAR_FORCED_OUT) begin
          // One-hot 1..32 drives one output, anything else clears them
          digital_out <= 6'h00; // RULE_16
          if (lw_val[15:6] == 10'h000 && (lw_val[5:0] & (lw_val[5:0] - 6'h01)) == 6'h00) begin
            digital_out <= lw_val[5:0];
          end
        end
      end else if (pend_q && tx_end) begin
        // The echo has gone out on the old settings
        baud_sel <= baud_pend_q; // RULE_14
        proto_q <= proto_pend_q; // RULE_15
        pend_q <= 1'b0;
      end
    end
  end

  // Parameter store: link writes win, software waits a cycle
  param_store store (
    .aclk(aclk),
    .we(link_we | sw_we),
    .waddr(link_we ? {cap_q[2][2:0], cap_q[3][6:0]} : psel_q),
    .wdata(link_we ? lw_val : sw_wdata),
    .raddr(psel_q),
    .rdata(mem_rdata)
  );

  // Parameter value seen by software, with fault words in place
  reg [15:0] pval;
  always @* begin
    if (psel_q == {3'h0, 7'h01}) begin
      pval = fault_code; // RULE_19
    end else if (psel_q[9:7] == 3'h4 && psel_q[6:0] <= 7'd4) begin
      pval = fault_history[psel_q[2:0] * 16 +: 16]; // RULE_19
    end else begin
      pval = mem_rdata;
    end
  end

  // AXI read: data one cycle after the address
  assign s_axi_arready = !ar_q && !s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      ar_q <= 1'b0;
      araddr_q <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_q <= 1'b1;
        araddr_q <= s_axi_araddr;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (ar_q) begin
        ar_q <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (araddr_q)
          `REG_CTRL: s_axi_rdata <= {24'h000000, station_q};
          `REG_STATUS: s_axi_rdata <= {unlock_q, 4'h0, pend_q, frame_verdict,
                                       6'h00, tst_q != T_PAY, rtu_mode};
          `REG_FRAME: s_axi_rdata <= {cap_q[1], cap_q[0], f_start};
          `REG_PSEL: s_axi_rdata <= {22'h000000, psel_q};
          `REG_PDATA: s_axi_rdata <= {16'h0000, pval};
          `REG_LINK: s_axi_rdata <= {proto_q, baud_sel};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
    end
  end
endmodule

/* File: sfca_asserts.sv */
// Purpose: Port checks for the frame check block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to the design at the foot of this file.
`timescale 1ns/100ps
module sfca_asserts #(
  parameter [23:0] IDLE_CYCLES = 24'd50
) (
  input wire aclk,
  input wire aresetn,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire tx_out_valid,
  input wire tx_out_ready,
  input wire [7:0] tx_out_data,
  input wire tx_out_last,
  input wire rtu_mode,
  input wire [15:0] baud_sel,
  input wire [5:0] digital_out,
  input wire frame_done,
  input wire [2:0] frame_verdict,
  input wire read_req,
  input wire [3:0] read_count
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire tx_end = tx_out_valid && tx_out_ready && tx_out_last; // Reply frame closes
  logic [23:0] idle_q; // Silent cycles on receive
  // Silence since the last byte, saturating
  always @(posedge aclk) begin
    if (!aresetn || rx_valid) idle_q <= 24'h0;
    else if (~&idle_q) idle_q <= idle_q + 24'h1;
  end
  property p_lf; frame_done && !rtu_mode |-> $past(rx_valid) && $past(rx_data) == 8'h0a; endproperty
  a_lf: assert property (p_lf) else $error("ascii end not on lf");
  property p_idle; frame_done && rtu_mode |-> idle_q >= IDLE_CYCLES; endproperty
  a_idle: assert property (p_idle) else $error("rtu end too early");
  property p_rd; read_req |-> frame_done && frame_verdict == 3'h1 && read_count != 4'h0; endproperty
  a_rd: assert property (p_rd) else $error("bad read request");
  property p_cnt; read_req |-> read_count <= 4'ha; endproperty
  a_cnt: assert property (p_cnt) else $error("read count above ten");
  property p_out; $past(aresetn) && $changed(digital_out) |-> $onehot0(digital_out); endproperty
  a_out: assert property (p_out) else $error("forced output not one-hot");
  property p_tx; tx_end && !rtu_mode |-> tx_out_data == 8'h0a; endproperty
  a_tx: assert property (p_tx) else $error("ascii reply not ended by lf");
  property p_baud; $past(aresetn) && $changed(baud_sel) |-> $past(tx_end); endproperty
  a_baud: assert property (p_baud) else $error("baud changed mid frame");
  property p_mode; $past(aresetn) && $changed(rtu_mode) |-> $past(tx_end); endproperty
  a_mode: assert property (p_mode) else $error("mode changed mid frame");
  property p_keep; frame_done && frame_verdict != 3'h1 |-> $stable(digital_out); endproperty
  a_keep: assert property (p_keep) else $error("refused frame acted on");
  c_read: cover property (read_req);
  c_rtu: cover property (frame_done && rtu_mode);
  c_tx: cover property (tx_end && rtu_mode);
endmodule
bind serial_frame_check_access sfca_asserts #(.IDLE_CYCLES(IDLE_CYCLES)) sfca_asserts_inst (.*);

/* File: host_link.sv */
// Purpose: Host model on the serial link.
// Assumes: One byte per rx_valid pulse.
// Notes: Replies collect in got, last flag in bit 8.
`timescale 1ns/100ps
module host_link (
  input wire aclk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_out_ready,
  input wire tx_out_valid,
  input wire [7:0] tx_out_data,
  input wire tx_out_last
);
  logic [8:0] got[$]; // Reply bytes
  logic slow = 0; // Stall every other cycle
  initial {rx_valid, rx_data, tx_out_ready} = 10'h1;
  // Capture replies; a slow host stalls
  always @(posedge aclk) begin
    if (tx_out_valid && tx_out_ready) got.push_back({tx_out_last, tx_out_data});
    tx_out_ready <= !slow || !tx_out_ready;
  end
  // Pulse a byte, then show its inverse
  task put(input [7:0] b);
    @(posedge aclk);
    {rx_valid, rx_data} <= {1'b1, b};
    @(posedge aclk);
    {rx_valid, rx_data} <= {1'b0, ~b};
  endtask
  // Start, body, CR, LF
  task ascii(input string s);
    put(8'h3a);
    for (int i = 0; i < s.len(); i++) put(s[i]);
    put(8'h0d);
    put(8'h0a);
  endtask
endmodule

/* File: serial_frame_check_access_tb.sv */
// Purpose: Bench for the frame check block.
// Assumes: IDLE_CYCLES of 50; host model on the link.
// Notes: Check bytes are worked by hand.
`timescale 1ns/100ps
module serial_frame_check_access_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic tx_in_valid, tx_in_last, seen, rq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, tx_in_data;
  logic [31:0] s_axi_wdata, rd;
  logic [1:0] rr;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_in_ready;
  wire rx_valid, tx_out_valid, tx_out_ready, tx_out_last, rtu_mode, frame_done, read_req;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] rx_data, tx_out_data;
  wire [15:0] baud_sel, read_start, fault_code = 16'h1234;
  wire [79:0] fault_history = 80'h0;
  wire [3:0] read_count, s_axi_wstrb = 4'hf;
  wire [5:0] digital_out;
  wire [2:0] frame_verdict;
  int errors, cmp_count;
  serial_frame_check_access #(.IDLE_CYCLES(24'd50)) serial_frame_check_access_inst (.*);
  host_link host_link_inst (.*);
  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end
  // Latch each frame end
  always @(posedge aclk) if (frame_done) {seen, rq} <= {1'b1, read_req};
  task chk(input [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task rdr(input [7:0] a);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    {rd, rr} = {s_axi_rdata, s_axi_rresp};
  endtask
  task wait_end(input [2:0] v);
    for (int n = 0; n < 99 && !seen; n++) @(posedge aclk);
    chk({seen, frame_verdict}, {1'b1, v});
  endtask
  task frame(input string s, input [2:0] v);
    seen = 0;
    host_link_inst.ascii(s);
    wait_end(v);
  endtask
  task tx(input logic [7:0] q[$]);
    host_link_inst.got.delete();
    foreach (q[i]) begin
      {tx_in_valid, tx_in_data, tx_in_last} <= {1'b1, q[i], i == q.size() - 1};
      do @(posedge aclk); while (!tx_in_ready);
    end
    {tx_in_valid, tx_in_last} <= 2'h0;
    repeat (20) @(posedge aclk);
  endtask
  task t_regs;
    rdr(8'h00);
    chk(rd, 32'h1);
    rdr(8'h20);
    chk(rr, 2'h2);
    wr(8'h0c, 32'h1);
    rdr(8'h10);
    chk(rd[15:0], 16'h1234);
    $display("regs done");
  endtask
  task t_access;
    frame("010602080014DB", 3'h1);
    frame("010602080015DB", 3'h2);
    frame("020602080015D9", 3'h3);
    frame("010600010005F3", 3'h5);
    frame("01030460000197", 3'h5);
    frame("01030200000BEF", 3'h5);
    frame("01030200000AF0", 3'h1);
    chk({rq, read_start, read_count}, {1'b1, 16'h0200, 4'ha});
    wr(8'h0c, 32'h108);
    rdr(8'h10);
    chk(rd[15:0], 16'h0014);
    frame("010604060020CF", 3'h1);
    chk(digital_out, 6'h20);
    frame("010604060000EF", 3'h1);
    chk(digital_out, 6'h00);
    $display("access done");
  endtask
  logic [7:0] rf[8] = '{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64, 8'h89, 8'h99};
  task t_mode;
    frame("010603010003F2", 3'h1);
    frame("010603020006EE", 3'h1);
    chk({baud_sel, rtu_mode}, 17'h0);
    tx({8'h3a, 8'h30, 8'h31});
    chk({host_link_inst.got[3], host_link_inst.got[4]}, 18'h08c46);
    chk({host_link_inst.got[5], host_link_inst.got[6]}, 18'h01b0a);
    chk({baud_sel, rtu_mode}, 17'h7);
    host_link_inst.slow = 1;
    tx({8'h01, 8'h03, 8'h01, 8'h01, 8'h00, 8'h02});
    chk({host_link_inst.got[6], host_link_inst.got[7]}, 18'h12937);
    seen = 0;
    foreach (rf[i]) host_link_inst.put(rf[i]);
    wait_end(3'h1);
    wr(8'h0c, 32'h100);
    rdr(8'h10);
    chk(rd[15:0], 16'h0064);
    $display("mode done");
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {tx_in_valid, tx_in_last, seen, rq, s_axi_awaddr, s_axi_araddr, tx_in_data} = 28'h0;
    s_axi_wdata = 32'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    t_regs;
    t_access;
    t_mode;
    print_verdict;
  end
  // Cut a hang short
  initial begin
    #100000;
    errors++;
    print_verdict;
  end
endmodule
